// ==== design/ddc_pkg.sv ====
/*
 Package for the datapath control register block: offsets, field positions,
 reset value, interpolation codes and the packed carrier of decoded controls.
 Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
*/
package ddc_pkg;
    localparam logic [7:0] DDC_OFF_CTRL = 8'h00;
    localparam logic [15:0] DDC_CTRL_RST = 16'h049C;
    localparam int DDC_B_P1_OFS = 15;
    localparam int DDC_B_P2_OFS = 14;
    localparam int DDC_B_P1_GP = 13;
    localparam int DDC_B_P2_GP = 12;
    localparam int DDC_B_INTERP_HI = 11;
    localparam int DDC_B_INTERP_LO = 8;
    localparam int DDC_B_FIFO = 7;
    localparam int DDC_B_ALM_OE = 4;
    localparam int DDC_B_ALM_POL = 3;
    localparam int DDC_B_SYNC = 2;
    localparam int DDC_B_P1_SINC = 1;
    localparam int DDC_B_P2_SINC = 0;
    // bits 6:5 are reserved and read back as written
    localparam logic [15:0] DDC_CTRL_MASK = 16'hFF9F;

    typedef enum logic [2:0] {
        DDC_INTERP_X1 = 3'h0,
        DDC_INTERP_X2 = 3'h1,
        DDC_INTERP_X4 = 3'h2,
        DDC_INTERP_X8 = 3'h3,
        DDC_INTERP_X16 = 3'h4,
        DDC_INTERP_BAD = 3'h7
    } ddc_interp_e;

    typedef struct packed {
        logic pair1_offset_fix_en;
        logic pair2_offset_fix_en;
        logic pair1_gain_phase_fix_en;
        logic pair2_gain_phase_fix_en;
        ddc_interp_e interp;
        logic fifo_en;
        logic alarm_drive_en;
        logic alarm_active_high;
        logic divclk_sync_en;
        logic pair1_sinc_comp_en;
        logic pair2_sinc_comp_en;
    } ddc_ctrl_s;
endpackage

// ==== design/ddc_ctrl_reg.sv ====
/*
 Datapath control register: one 16-bit register on Avalon-MM with decoded
 control outputs, alarm pin drive and sync-pointer request.
 Assumes the alarm source and sync pulse come from logic on CLK_SYS.
*/
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps

module ddc_ctrl_reg (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output ddc_pkg::ddc_ctrl_s CTRL,
    input wire logic ALARM_EVENT,
    output logic ALARM_O,
    output logic ALARM_OE,
    input wire logic SYNC_PULSE,
    output logic FIFO_OUTPTR_RESYNC
);

    logic [15:0] ctrl_q;
    logic ack_q;
    logic hit;
    logic alarm_q;
    logic resync_q;

    // map the one-hot or all-zero field onto the internal code; other codes flagged
    function automatic ddc_pkg::ddc_interp_e interp_dec(input logic [3:0] f);
        case (f)
            4'h0: interp_dec = ddc_pkg::DDC_INTERP_X1;
            4'h1: interp_dec = ddc_pkg::DDC_INTERP_X2;
            4'h2: interp_dec = ddc_pkg::DDC_INTERP_X4;
            4'h4: interp_dec = ddc_pkg::DDC_INTERP_X8;
            4'h8: interp_dec = ddc_pkg::DDC_INTERP_X16;
            default: interp_dec = ddc_pkg::DDC_INTERP_BAD;
        endcase
    endfunction

    assign hit = (AVS_ADDRESS == ddc_pkg::DDC_OFF_CTRL);

    // one wait cycle per access: answer comes on the second edge
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
        end
    end
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;

    // register write, low two byte lanes only
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_q <= ddc_pkg::DDC_CTRL_RST;
        end else if (AVS_WRITE && ack_q && hit) begin
            if (AVS_BYTEENABLE[0]) begin
                ctrl_q[7:0] <= AVS_WRITEDATA[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
                ctrl_q[15:8] <= AVS_WRITEDATA[15:8];
            end
        end
    end

    // read data registered; unmapped reads return zero
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && !ack_q) begin
            AVS_READDATA <= hit ? {16'h0000, ctrl_q} : 32'h0000_0000;
        end
    end

    // decoded controls straight from flops
    always_comb begin
        CTRL.pair1_offset_fix_en = ctrl_q[ddc_pkg::DDC_B_P1_OFS];
        CTRL.pair2_offset_fix_en = ctrl_q[ddc_pkg::DDC_B_P2_OFS];
        CTRL.pair1_gain_phase_fix_en = ctrl_q[ddc_pkg::DDC_B_P1_GP];
        CTRL.pair2_gain_phase_fix_en = ctrl_q[ddc_pkg::DDC_B_P2_GP];
        CTRL.interp = interp_dec(ctrl_q[ddc_pkg::DDC_B_INTERP_HI:ddc_pkg::DDC_B_INTERP_LO]);
        CTRL.fifo_en = ctrl_q[ddc_pkg::DDC_B_FIFO];
        CTRL.alarm_drive_en = ctrl_q[ddc_pkg::DDC_B_ALM_OE];
        CTRL.alarm_active_high = ctrl_q[ddc_pkg::DDC_B_ALM_POL];
        CTRL.divclk_sync_en = ctrl_q[ddc_pkg::DDC_B_SYNC];
        CTRL.pair1_sinc_comp_en = ctrl_q[ddc_pkg::DDC_B_P1_SINC];
        CTRL.pair2_sinc_comp_en = ctrl_q[ddc_pkg::DDC_B_P2_SINC];
    end

    // alarm pin level registered so polarity flips glitch-free
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            alarm_q <= 1'b0;
        end else begin
            alarm_q <= ctrl_q[ddc_pkg::DDC_B_ALM_POL] ? ALARM_EVENT : ~ALARM_EVENT;
        end
    end
    assign ALARM_O = alarm_q;
    assign ALARM_OE = ctrl_q[ddc_pkg::DDC_B_ALM_OE];

    // pointer resync only when enabled; pulse follows the sync source
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            resync_q <= 1'b0;
        end else begin
            resync_q <= SYNC_PULSE & ctrl_q[ddc_pkg::DDC_B_SYNC];
        end
    end
    assign FIFO_OUTPTR_RESYNC = resync_q;

    a_write_lands: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (AVS_WRITE && !AVS_WAITREQUEST && hit && AVS_BYTEENABLE[1])
        |=> CTRL.pair1_offset_fix_en == $past(AVS_WRITEDATA[15]))
        else $error("offset enable did not follow write");
    a_gp_lands: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (AVS_WRITE && !AVS_WAITREQUEST && hit && AVS_BYTEENABLE[1])
        |=> CTRL.pair2_gain_phase_fix_en == $past(AVS_WRITEDATA[12]))
        else $error("gain phase enable did not follow write");
    a_interp_x8: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (ctrl_q[11:8] == 4'h4) |-> CTRL.interp == ddc_pkg::DDC_INTERP_X8)
        else $error("interp code 0100 not decoded as 8x");
    a_fifo_bit: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (AVS_WRITE && !AVS_WAITREQUEST && hit && AVS_BYTEENABLE[0])
        |=> CTRL.fifo_en == $past(AVS_WRITEDATA[7]))
        else $error("fifo enable did not follow write");
    a_alarm_oe: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ALARM_OE == CTRL.alarm_drive_en)
        else $error("alarm drive not tied to enable");
    a_alarm_pol: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        $stable(ctrl_q[3]) |=> ALARM_O == ($past(ctrl_q[3]) ? $past(ALARM_EVENT) : !$past(ALARM_EVENT)))
        else $error("alarm level wrong for polarity");
    a_resync_gate: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (SYNC_PULSE && ctrl_q[2]) |=> FIFO_OUTPTR_RESYNC)
        else $error("resync missed while enabled");
    a_no_resync: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !$past(ctrl_q[2]) |-> !FIFO_OUTPTR_RESYNC)
        else $error("resync while disabled");
    a_sinc_read: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (AVS_READ && !AVS_WAITREQUEST && hit) |-> AVS_READDATA[1:0] == {CTRL.pair1_sinc_comp_en,
        CTRL.pair2_sinc_comp_en})
        else $error("readback of sinc bits wrong");
    a_wait_one: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ($rose(AVS_READ) || $rose(AVS_WRITE)) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("answer not one cycle after request");
    // second pair enables checked too, so a swapped bit pair cannot hide
    a_ofs2_lands: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (AVS_WRITE && !AVS_WAITREQUEST && hit && AVS_BYTEENABLE[1])
        |=> CTRL.pair2_offset_fix_en == $past(AVS_WRITEDATA[14]))
        else $error("second offset enable did not follow write");
    a_x16_code: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (ctrl_q[11:8] == 4'h8) |-> CTRL.interp == ddc_pkg::DDC_INTERP_X16)
        else $error("interp code 1000 not decoded as 16x");
    a_sinc1_lands: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (AVS_WRITE && !AVS_WAITREQUEST && hit && AVS_BYTEENABLE[0])
        |=> CTRL.pair1_sinc_comp_en == $past(AVS_WRITEDATA[1]))
        else $error("first sinc enable did not follow write");
    a_unmapped_rd: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (AVS_READ && !AVS_WAITREQUEST && !hit) |-> AVS_READDATA == 32'h0000_0000)
        else $error("unmapped read returned nonzero");

endmodule // ddc_ctrl_reg

// ==== sim/test_ddc_ctrl_reg.sv ====
/*
 Self-checking bench for the datapath control register.
 Assumes one clock, registered read data and one wait cycle per access.
*/
`timescale 1ns/1ps
module test_ddc_ctrl_reg;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rdq = 1'b0;
    logic wrq = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic wait_q;
    ddc_pkg::ddc_ctrl_s ctrl;
    logic ev = 1'b0;
    logic alm;
    logic alm_oe;
    logic sp = 1'b0;
    logic rsy;
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
    logic [2:0] dec [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [15:0] v;
    ddc_ctrl_reg ddc_ctrl_reg_inst (.CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rdq),
        .AVS_WRITE(wrq), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_q), .CTRL(ctrl), .ALARM_EVENT(ev), .ALARM_O(alm), .ALARM_OE(alm_oe),
        .SYNC_PULSE(sp), .FIFO_OUTPTR_RESYNC(rsy));
    // free-running 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // one access; request held until the rising edge that sees wait low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        be <= b;
        wrq <= w;
        rdq <= !w;
        @(posedge clk);
        while (wait_q !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        rd = rdata;
        if (n >= 50) error_cnt++;
        wrq <= 1'b0;
        rdq <= 1'b0;
        @(posedge clk);
    endtask
    // readback, decoded controls and pin enable
    task automatic check_reg(input logic [15:0] r);
        logic [2:0] c;
        c = 3'h7;
        for (int i = 0; i < 6; i++) if (codes[i] == r[11:8]) c = dec[i];
        bus(1'b0, 8'h00, 32'h0, 4'hF);
        chk("readback", {16'h0, r}, rd);
        chk("ctrl", {19'h0, r[15:12], c, r[7], r[4:0]}, 32'(ctrl));
        chk("alarm_oe", {31'h0, r[4]}, {31'h0, alm_oe});
    endtask
    task automatic t_alarm(input logic [15:0] r);
        bus(1'b1, 8'h00, {16'h0, r}, 4'hF);
        check_reg(r);
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            ev <= e[0];
            @(posedge clk);
            @(negedge clk);
            chk("alarm_o", {31'h0, e[0] ~^ r[3]}, {31'h0, alm});
        end
    endtask
    // resync only follows the pulse while bit 2 is set
    task automatic t_sync(input logic [15:0] r);
        bus(1'b1, 8'h00, {16'h0, r}, 4'hF);
        sp <= 1'b1;
        @(posedge clk);
        sp <= 1'b0;
        @(negedge clk);
        chk("resync", {31'h0, r[2]}, {31'h0, rsy});
        @(negedge clk);
        chk("resync_end", 32'h0, {31'h0, rsy});
        @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard, well beyond the hundred or so cycles used
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_reg(16'h049C);
        for (int i = 0; i < 6; i++) begin
            v = {i[0] ? 4'hA : 4'h5, codes[i], i[0], 2'b00, i[0] ? 5'h15 : 5'h0A};
            bus(1'b1, 8'h00, {16'h0, v}, 4'hF);
            check_reg(v);
        end
        bus(1'b1, 8'h00, 32'h0, 4'hF);
        bus(1'b1, 8'h00, 32'hFFFF_F29F, 4'h2);
        check_reg(16'hF200);
        bus(1'b1, 8'h04, 32'h0000_FFFF, 4'hF);
        bus(1'b0, 8'h04, 32'h0, 4'hF);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, 8'h00, 32'hFFFF_FF9F, 4'h1);
        check_reg(16'hF29F);
        t_alarm(16'h0494);
        t_alarm(16'h0488);
        t_alarm(16'h049C);
        t_sync(16'h049C);
        t_sync(16'h0498);
        wrap_up();
    end
endmodule // test_ddc_ctrl_reg
